/* hdl/css_pkg.sv */
// Package with constants, types and operation summary for the clock source and start-up control block
// Summary of operation
// - Decode 4-bit source select fuse field
// - Fuse bit 1 unprogrammed, 0 programmed
// - Wake from power-down or power-save counts selected-clock start-up cycles
// - Reset adds none, 4096 or 65536 watchdog cycles
// - Shipped: RC source, longest start-up, divide-by-eight
// - Reset loads factory calibration into calibration register
// - Software may rewrite calibration to retune oscillator
// - Watchdog oscillator always clocks watchdog and time-out
// - RC start-up: 6CK wake, 14CK plus option
// - Crystal upper bits choose amplifier frequency range
// - Crystal bit0 clear: 258CK or 1K CK
// - Crystal bit0 set: 1K CK or 16K CK
// - Gate unused clock domains per sleep mode
// - Peripheral clock feeds timers, serial, interrupts
// - Async timer domain keeps counting in idle, noise and power-save sleep
// - Converter clock runs in idle and noise modes while core clocks halt
// - RC nominal 8MHz, divided by eight if programmed
// - Program-memory clock follows core clock
// - Low-frequency crystal codes give 1K or 32K CK
package css_pkg;

	// Fuse field widths and raw codes, read with 1 meaning unprogrammed
	localparam int SEL_W = 4;
	localparam int SUT_W = 2;
	localparam int CAL_W = 8;
	localparam int CNT_W = 17;
	localparam logic [3:0] SEL_RC = 4'h2;
	localparam logic [3:0] SEL_EXT = 4'h0;
	localparam logic [3:0] SEL_LF_FAST = 4'h6;
	localparam logic [3:0] SEL_LF_SLOW = 4'h7;
	localparam logic [1:0] SUT_RESERVED = 2'h3;

	// Shipped fuse settings and the neutral factory calibration used before the array is sampled
	localparam logic [3:0] SHIP_SEL = 4'h2;
	localparam logic [1:0] SHIP_SUT = 2'h2;
	localparam logic SHIP_DIV8 = 1'b0;
	localparam logic [7:0] FACTORY_CAL_RST = 8'h80;
	localparam logic [7:0] CAL_RST = 8'h80;

	// Start-up counts in cycles of the selected source or of the watchdog oscillator
	localparam logic [16:0] CK_RESET = 17'h0000e;
	localparam logic [16:0] CK_WAKE_SHORT = 17'h00006;
	localparam logic [16:0] CK_WAKE_258 = 17'h00102;
	localparam logic [16:0] CK_WAKE_1K = 17'h00400;
	localparam logic [16:0] WDT_SHORT_CYCLES = 17'h01000;

	// Register indices on the plain register port
	localparam int ADDR_W = 2;
	localparam logic [1:0] REG_CAL = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_FUSE = 2'h2;

	// Decoded source family
	typedef enum logic [2:0] {K_XTAL, K_LFXTAL, K_RC, K_EXT, K_BAD} css_kind_e;
	// Extra watchdog delay after a reset
	typedef enum logic [1:0] {W_NONE, W_SHORT, W_LONG, W_BAD} css_wdt_e;
	// Sleep modes as presented by the power manager
	typedef enum logic [2:0] {M_IDLE, M_NOISE, M_PDOWN, M_PSAVE, M_STANDBY} css_sleep_e;
	// Start-up sequencer states
	typedef enum logic [2:0] {S_LOAD, S_RST_CK, S_RST_WDT, S_RUN, S_SLEEP, S_WAKE_CK, S_INVALID} css_state_e;

endpackage

/* hdl/css_cnt_if.sv */
// Interface between the start-up sequencer and its cycle counter
`timescale 1ns/1ps
interface css_cnt_if;
	logic clear; // Restart the count at zero
	logic tick; // One-cycle pulse per counted oscillator cycle
	logic [16:0] target; // Number of ticks to wait
	logic done; // Count has reached the target
	modport ctrl (output clear, output tick, output target, input done);
	modport cnt (input clear, input tick, input target, output done);
endinterface

/* hdl/css_sync.sv */
// Two-stage synchroniser with a constant reset value
`timescale 1ns/1ps
module css_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg; // First stage, read only by the second

	// Both stages reset to a constant; the caller reads only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule

/* hdl/css_counter.sv */
// Tick counter used for every start-up delay
`timescale 1ns/1ps
module css_counter
	import css_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	css_cnt_if.cnt cnt
);
	logic [16:0] count_reg; // Ticks seen since last clear

	// Compare against the live target so one counter serves all phases
	assign cnt.done = (count_reg >= cnt.target);

	// Saturates at the target so a late tick cannot wrap past it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_reg <= '0;
		end else if (cnt.clear) begin
			count_reg <= '0;
		end else if (cnt.tick && !cnt.done) begin
			count_reg <= count_reg + 17'h00001;
		end
	end
endmodule

/* hdl/css_top.sv */
// Clock source decode, start-up sequencer, calibration and clock domain gating
`timescale 1ns/1ps
module css_top
	import css_pkg::*;
#(
	parameter int WDT_LONG_CYCLES = 65536, // Long reset delay in watchdog cycles
	parameter int CK_WAKE_16K = 16384, // Crystal wake delay in source cycles
	parameter int CK_WAKE_32K = 32768 // Low-frequency crystal slow wake delay
) (
	input wire logic I_REF_CLK,
	input wire logic I_SYS_RST,
	input wire logic [3:0] I_CLOCK_SOURCE_SELECT_FUSES,
	input wire logic [1:0] I_STARTUP_TIME_FUSES,
	input wire logic I_DIVIDE_BY_EIGHT_FUSE,
	input wire logic [7:0] I_FACTORY_CAL,
	input wire logic I_SRC_OSC,
	input wire logic I_WDT_OSC,
	input wire logic I_SLEEP_REQ,
	input wire logic [2:0] I_SLEEP_MODE,
	input wire logic I_WAKE,
	input wire logic [1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	output logic O_CORE_CLK_EN,
	output logic O_PERIPH_CLK_EN,
	output logic O_PMEM_CLK_EN,
	output logic O_ASYNC_CLK_EN,
	output logic O_CONV_CLK_EN,
	output logic O_ASYNC_DETECT_EN,
	output logic O_WDT_OSC_EN,
	output logic O_OSC_EN,
	output logic [2:0] O_SRC_KIND,
	output logic [1:0] O_XTAL_RANGE,
	output logic O_DIV8,
	output logic [7:0] O_RC_CALIBRATION_VALUE,
	output logic O_CPU_RUN,
	output logic O_CFG_INVALID
);

	// All state of the block except synchronisers and counter in one record
	typedef struct packed {
		css_state_e state;
		css_sleep_e sleep;
		css_kind_e kind;
		css_wdt_e wdt;
		logic [7:0] cal;
		logic [7:0] rdata;
		logic src_prev;
		logic wdt_prev;
		logic core_en;
		logic periph_en;
		logic pmem_en;
		logic async_en;
		logic conv_en;
		logic detect_en;
		logic wdt_en;
		logic osc_en;
		logic [1:0] range;
		logic div8;
		logic run;
		logic invalid;
	} css_regs_s;

	css_regs_s s_reg; // Registered state
	css_regs_s s_next; // Next state
	logic [14:0] fuse_sync; // Synchronised {cal, div8, sut, sel}
	logic [1:0] osc_sync; // Synchronised {wdt osc, src osc}
	logic [3:0] sel; // Source select fuses, 1 = unprogrammed
	logic [1:0] startup_time_fuses; // Start-up fuses
	logic [7:0] factory_cal; // Factory calibration byte
	logic src_tick; // Rising edge of the selected source
	logic wdt_tick; // Rising edge of the watchdog oscillator
	css_cnt_if cnt_bus ();

	// Fuse stages stay out of the system reset: the fuses fill both stages while reset is held,
	// so the load cycle after release sees the real code; the shipped code is only the stage default
	css_sync #(
		.W(15),
		.RST_VAL({FACTORY_CAL_RST, SHIP_DIV8, SHIP_SUT, SHIP_SEL})
	) u_fuse_sync (
		.i_clk(I_REF_CLK),
		.i_rst(1'b0),
		.i_d({I_FACTORY_CAL, I_DIVIDE_BY_EIGHT_FUSE, I_STARTUP_TIME_FUSES, I_CLOCK_SOURCE_SELECT_FUSES}),
		.o_q(fuse_sync)
	);

	// Oscillator levels arrive from other clocks and are edge-detected after two stages
	css_sync #(
		.W(2),
		.RST_VAL(2'h0)
	) u_osc_sync (
		.i_clk(I_REF_CLK),
		.i_rst(I_SYS_RST),
		.i_d({I_WDT_OSC, I_SRC_OSC}),
		.o_q(osc_sync)
	);

	// One counter serves reset, watchdog and wake phases in turn
	css_counter u_counter (
		.i_clk(I_REF_CLK),
		.i_rst(I_SYS_RST),
		.cnt(cnt_bus.cnt)
	);

	assign sel = fuse_sync[3:0];
	assign startup_time_fuses = fuse_sync[5:4];
	assign factory_cal = fuse_sync[14:7];
	assign src_tick = osc_sync[0] && !s_reg.src_prev;
	assign wdt_tick = osc_sync[1] && !s_reg.wdt_prev;

	// Source family from the select field; raw compare keeps fuse polarity
	function automatic css_kind_e decode_kind(input logic [3:0] f);
		if (f[3]) begin
			decode_kind = K_XTAL;
		end else if (f == SEL_LF_FAST || f == SEL_LF_SLOW) begin
			decode_kind = K_LFXTAL;
		end else if (f == SEL_RC) begin
			decode_kind = K_RC;
		end else if (f == SEL_EXT) begin
			decode_kind = K_EXT;
		end else begin
			decode_kind = K_BAD;
		end
	endfunction

	// Extra reset delay in watchdog cycles for each source and start-up code
	function automatic css_wdt_e decode_wdt(input css_kind_e k, input logic b0, input logic [1:0] t);
		decode_wdt = W_BAD;
		if (k == K_XTAL) begin
			unique case ({b0, t})
				3'h0: decode_wdt = W_SHORT;
				3'h1: decode_wdt = W_LONG;
				3'h2: decode_wdt = W_NONE;
				3'h3: decode_wdt = W_SHORT;
				3'h4: decode_wdt = W_LONG;
				3'h5: decode_wdt = W_NONE;
				3'h6: decode_wdt = W_SHORT;
				3'h7: decode_wdt = W_LONG;
			endcase
		end else if (k != K_BAD) begin
			unique case (t)
				2'h0: decode_wdt = W_NONE;
				2'h1: decode_wdt = W_SHORT;
				2'h2: decode_wdt = W_LONG;
				2'h3: decode_wdt = W_BAD;
			endcase
		end
	endfunction

	// Wake start-up length in cycles of the selected source
	function automatic logic [16:0] wake_cycles(input css_kind_e k, input logic b0, input logic [1:0] t);
		wake_cycles = CK_WAKE_SHORT;
		if (k == K_XTAL) begin
			if (!b0) begin
				wake_cycles = t[1] ? CK_WAKE_1K : CK_WAKE_258;
			end else begin
				wake_cycles = (t == 2'h0) ? CK_WAKE_1K : CK_WAKE_16K[16:0];
			end
		end else if (k == K_LFXTAL) begin
			wake_cycles = b0 ? CK_WAKE_32K[16:0] : CK_WAKE_1K;
		end
	endfunction

	// Domain enables {core, periph, pmem, async, conv} for each sleep mode
	function automatic logic [4:0] sleep_mask(input css_sleep_e m);
		unique case (m)
			M_IDLE: sleep_mask = 5'h0b; // Core stopped, peripherals keep going
			M_NOISE: sleep_mask = 5'h03;
			M_PSAVE: sleep_mask = 5'h02;
			M_PDOWN: sleep_mask = 5'h00;
			M_STANDBY: sleep_mask = 5'h00;
			default: sleep_mask = 5'h00; // Undefined mode codes stop every domain
		endcase
	endfunction

	// Counter target and tick source follow the sequencer phase
	always_comb begin
		cnt_bus.tick = src_tick;
		cnt_bus.target = CK_RESET;
		unique case (s_reg.state)
			S_RST_WDT: begin
				cnt_bus.tick = wdt_tick;
				cnt_bus.target = (s_reg.wdt == W_LONG) ? WDT_LONG_CYCLES[16:0] : WDT_SHORT_CYCLES;
			end
			S_WAKE_CK: begin
				cnt_bus.target = wake_cycles(s_reg.kind, sel[0], startup_time_fuses);
			end
			default: begin
				cnt_bus.target = CK_RESET;
			end
		endcase
	end

	// Sequencer, registers and domain gating
	always_comb begin
		logic [4:0] mask;
		mask = 5'h00;
		s_next = s_reg;
		cnt_bus.clear = 1'b0;
		s_next.src_prev = osc_sync[0];
		s_next.wdt_prev = osc_sync[1];
		s_next.wdt_en = 1'b1;
		s_next.detect_en = 1'b1;
		s_next.rdata = 8'h00;

		unique case (s_reg.state)
			// Fuses and factory byte are stable now; the core is still held
			S_LOAD: begin
				s_next.cal = factory_cal;
				s_next.kind = decode_kind(sel);
				s_next.wdt = decode_wdt(decode_kind(sel), sel[0], startup_time_fuses);
				s_next.range = sel[2:1];
				s_next.div8 = !fuse_sync[6];
				cnt_bus.clear = 1'b1;
				if (decode_kind(sel) == K_BAD || decode_wdt(decode_kind(sel), sel[0], startup_time_fuses) == W_BAD) begin
					s_next.state = S_INVALID;
				end else begin
					s_next.osc_en = 1'b1;
					s_next.state = S_RST_CK;
				end
			end
			// Fixed source-cycle part of the reset delay
			S_RST_CK: begin
				if (cnt_bus.done) begin
					cnt_bus.clear = 1'b1;
					s_next.state = (s_reg.wdt == W_NONE) ? S_RUN : S_RST_WDT;
				end
			end
			// Real-time part, timed by the watchdog oscillator
			S_RST_WDT: begin
				if (cnt_bus.done) begin
					s_next.state = S_RUN;
				end
			end
			S_RUN: begin
				if (I_SLEEP_REQ) begin
					s_next.sleep = css_sleep_e'(I_SLEEP_MODE);
					s_next.state = S_SLEEP;
				end
			end
			// Only power-down and power-save need a new start-up; the source enable stays on in every mode
			S_SLEEP: begin
				if (I_WAKE) begin
					cnt_bus.clear = 1'b1;
					if (s_reg.sleep == M_PDOWN || s_reg.sleep == M_PSAVE) begin
						s_next.state = S_WAKE_CK;
					end else begin
						s_next.state = S_RUN;
					end
				end
			end
			S_WAKE_CK: begin
				if (cnt_bus.done) begin
					s_next.state = S_RUN;
				end
			end
			// Bad fuses: source and core stay off until the next reset
			S_INVALID: begin
				s_next.osc_en = 1'b0;
			end
		endcase

		// Domain gating from the next state so enables change with it
		unique case (s_next.state)
			S_RUN: mask = 5'h1f;
			S_SLEEP: mask = sleep_mask(s_next.sleep);
			S_RST_CK, S_RST_WDT, S_WAKE_CK: mask = 5'h00;
			default: mask = 5'h00;
		endcase
		s_next.core_en = mask[4];
		s_next.periph_en = mask[3];
		s_next.pmem_en = mask[4];
		s_next.async_en = mask[1] || s_next.state == S_RUN;
		s_next.conv_en = mask[0];
		s_next.run = (s_next.state == S_RUN);
		s_next.invalid = (s_next.state == S_INVALID);

		// Software writes retune the oscillator at once
		if (I_WR && I_ADDR == REG_CAL && s_reg.state != S_LOAD) begin
			s_next.cal = I_WDATA;
		end
		// Read data stand only in the cycle after the strobe
		if (I_RD) begin
			unique case (I_ADDR)
				REG_CAL: s_next.rdata = s_reg.cal;
				REG_STATUS: s_next.rdata = {1'b0, s_reg.state, s_reg.invalid, s_reg.run, s_reg.div8, s_reg.osc_en};
				REG_FUSE: s_next.rdata = {1'b0, fuse_sync[6:0]};
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			s_reg <= '{
				state: S_LOAD,
				sleep: M_IDLE,
				kind: K_RC,
				wdt: W_LONG,
				cal: CAL_RST,
				rdata: 8'h00,
				src_prev: 1'b0,
				wdt_prev: 1'b0,
				core_en: 1'b0,
				periph_en: 1'b0,
				pmem_en: 1'b0,
				async_en: 1'b0,
				conv_en: 1'b0,
				detect_en: 1'b0,
				wdt_en: 1'b1,
				osc_en: 1'b0,
				range: 2'h0,
				div8: 1'b1,
				run: 1'b0,
				invalid: 1'b0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign O_RDATA = s_reg.rdata;
	assign O_CORE_CLK_EN = s_reg.core_en;
	assign O_PERIPH_CLK_EN = s_reg.periph_en;
	assign O_PMEM_CLK_EN = s_reg.pmem_en;
	assign O_ASYNC_CLK_EN = s_reg.async_en;
	assign O_CONV_CLK_EN = s_reg.conv_en;
	assign O_ASYNC_DETECT_EN = s_reg.detect_en;
	assign O_WDT_OSC_EN = s_reg.wdt_en;
	assign O_OSC_EN = s_reg.osc_en;
	assign O_SRC_KIND = s_reg.kind;
	assign O_XTAL_RANGE = s_reg.range;
	assign O_DIV8 = s_reg.div8;
	assign O_RC_CALIBRATION_VALUE = s_reg.cal;
	assign O_CPU_RUN = s_reg.run;
	assign O_CFG_INVALID = s_reg.invalid;

endmodule

/* verif/css_chk.sv */
// Port-level assertions for the clock source and start-up block
`timescale 1ns/1ps
module css_chk
	import css_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_DIVIDE_BY_EIGHT_FUSE,
	input wire logic [7:0] I_FACTORY_CAL,
	input wire logic I_SLEEP_REQ,
	input wire logic [1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [7:0] O_RDATA,
	input wire logic O_CORE_CLK_EN,
	input wire logic O_PERIPH_CLK_EN,
	input wire logic O_PMEM_CLK_EN,
	input wire logic O_CONV_CLK_EN,
	input wire logic O_WDT_OSC_EN,
	input wire logic O_OSC_EN,
	input wire logic O_DIV8,
	input wire logic [7:0] O_RC_CALIBRATION_VALUE,
	input wire logic O_CPU_RUN,
	input wire logic O_CFG_INVALID
);
	// Single clock domain, so clock and reset are given once
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_SYS_RST);

	// Sleep request accepted while running
	sequence s_sleep_taken;
		O_CPU_RUN && I_SLEEP_REQ;
	endsequence
	// Core and execution halted
	sequence s_core_halted;
		!O_CPU_RUN && !O_CORE_CLK_EN;
	endsequence

	chk_sleep_halt: assert property (s_sleep_taken |=> s_core_halted)
		else $error("core kept running after sleep request");
	chk_wdt_osc_on: assert property (O_WDT_OSC_EN)
		else $error("watchdog oscillator disabled");
	chk_pmem_follow: assert property (O_PMEM_CLK_EN == O_CORE_CLK_EN)
		else $error("program memory clock differs from core clock");
	chk_run_clocks: assert property (O_CPU_RUN |-> O_CORE_CLK_EN && O_PERIPH_CLK_EN && O_CONV_CLK_EN && O_OSC_EN)
		else $error("running with a clock gated");
	chk_div_fuse: assert property (O_CPU_RUN |-> O_DIV8 == !I_DIVIDE_BY_EIGHT_FUSE)
		else $error("divide flag has wrong polarity");
	chk_cal_write: assert property (O_CPU_RUN && I_WR && I_ADDR == REG_CAL |=> O_RC_CALIBRATION_VALUE == $past(I_WDATA))
		else $error("calibration write lost");
	chk_cal_read: assert property (I_RD && I_ADDR == REG_CAL && !$past(I_SYS_RST) |=> O_RDATA == O_RC_CALIBRATION_VALUE)
		else $error("calibration read wrong");
	chk_cal_load: assert property ($fell(I_SYS_RST) |=> O_RC_CALIBRATION_VALUE == I_FACTORY_CAL)
		else $error("factory calibration not loaded");
	chk_invalid_off: assert property (O_CFG_INVALID |-> !O_OSC_EN && !O_CPU_RUN)
		else $error("source enabled on invalid fuses");
	chk_invalid_hold: assert property (O_CFG_INVALID |=> $stable(O_CFG_INVALID))
		else $error("invalid flag left before reset");
endmodule

bind css_top css_chk u_css_chk (.I_REF_CLK, .I_SYS_RST, .I_DIVIDE_BY_EIGHT_FUSE, .I_FACTORY_CAL, .I_SLEEP_REQ,
	.I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_CORE_CLK_EN, .O_PERIPH_CLK_EN, .O_PMEM_CLK_EN, .O_CONV_CLK_EN,
	.O_WDT_OSC_EN, .O_OSC_EN, .O_DIV8, .O_RC_CALIBRATION_VALUE, .O_CPU_RUN, .O_CFG_INVALID);

/* verif/testbench.sv */
// Self-checking bench for the clock source and start-up block
`timescale 1ns/1ps
module testbench
	import css_pkg::*;
;
	logic clk = 0, rst = 1, wdt = 0, src = 0, req = 0, wake = 0, wr = 0, rd = 0, div = 0, rd_d = 0;
	logic [3:0] sel = 4'h2;
	logic [1:0] startup_time_fuses = 2'h2, addr = 2'h0, rng;
	logic [2:0] mode = 3'h0, kind;
	logic [7:0] fcal = 8'h00, wd = 8'h00, rdata, cal, c;
	logic core, peri, pmem, asy, conv, det, wen, oen, dv8, run, inv;
	logic [15:0] rnd = 16'hed82; // Fixed seed
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	// Enables {core, periph, pmem, async, conv} per sleep mode
	logic [4:0] en_tbl[5] = '{5'h0b, 5'h03, 5'h00, 5'h02, 5'h00};
	// Fuse code, start-up code, family, reset watchdog cycles (-1 invalid), wake cycles
	int tbl[11][5] = '{'{2, 0, 2, 0, 6}, '{2, 1, 2, 4096, 6}, '{2, 2, 2, 40, 6}, '{0, 2, 3, 40, 6},
		'{13, 1, 0, 0, 30}, '{8, 1, 0, 40, 258}, '{10, 2, 0, 0, 1024}, '{6, 0, 1, 0, 1024},
		'{7, 2, 1, 40, 50}, '{3, 0, 4, -1, 0}, '{2, 3, 2, -1, 0}};
	int n_fail = 0, n_checks = 0;

	// Long counts shortened so the run stays brief
	css_top #(.WDT_LONG_CYCLES(40), .CK_WAKE_16K(30), .CK_WAKE_32K(50)) u_css_top (
		.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLOCK_SOURCE_SELECT_FUSES(sel), .I_STARTUP_TIME_FUSES(startup_time_fuses),
		.I_DIVIDE_BY_EIGHT_FUSE(div), .I_FACTORY_CAL(fcal), .I_SRC_OSC(src), .I_WDT_OSC(wdt),
		.I_SLEEP_REQ(req), .I_SLEEP_MODE(mode), .I_WAKE(wake), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .O_CORE_CLK_EN(core), .O_PERIPH_CLK_EN(peri), .O_PMEM_CLK_EN(pmem),
		.O_ASYNC_CLK_EN(asy), .O_CONV_CLK_EN(conv), .O_ASYNC_DETECT_EN(det), .O_WDT_OSC_EN(wen),
		.O_OSC_EN(oen), .O_SRC_KIND(kind), .O_XTAL_RANGE(rng), .O_DIV8(dv8),
		.O_RC_CALIBRATION_VALUE(cal), .O_CPU_RUN(run), .O_CFG_INVALID(inv));

	// 10 MHz system clock
	initial forever #50 clk = ~clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Oscillator pulses held long enough for the two-flop synchroniser
	task automatic osc(input bit s, input int n);
		repeat (n) begin
			if (s) src <= 1;
			else wdt <= 1;
			cyc(3);
			src <= 0;
			wdt <= 0;
			cyc(3);
		end
	endtask

	// One strobe cycle, then an idle cycle so strobes never double-assign
	task automatic bus(input bit w, input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		cyc(1);
		wr <= 0;
		rd <= 0;
		cyc(1);
	endtask

	task automatic rdx(input logic [1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(0, a, 8'h00);
	endtask

	// Bounded wait for execution release
	task automatic wait_run;
		for (int i = 0; i < 16 && run !== 1'b1; i++) cyc(1);
		chk(run, 1);
		// A sequencer that never releases ends the run here
		if (run !== 1'b1) end_sim;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_d) chk(rdata, exp_q.pop_front());
		rd_d <= rd;
	end

	// Hang guard
	initial begin
		cyc(90000);
		n_fail++;
		end_sim;
	end

	initial begin
		for (int i = 0; i < 11; i++) begin
			sel <= 4'(tbl[i][0]);
			startup_time_fuses <= 2'(tbl[i][1]);
			div <= rnd[0];
			fcal <= rnd[15:8];
			rnd = lfsr(rnd);
			rst <= 1;
			cyc(4);
			chk({run, wen, dv8, kind}, 6'h1a);
			rst <= 0;
			cyc(2);
			chk(cal, fcal);
			chk(kind, tbl[i][2]);
			chk(dv8, !div);
			chk({rng, det}, {sel[2:1], 1'b1});
			chk(inv, tbl[i][3] < 0);
			rdx(2'h2, {1'b0, div, startup_time_fuses, sel});
			if (tbl[i][3] < 0) begin
				// Reserved codes must never start the source or execution
				osc(1, 20);
				chk({run, oen}, 0);
				continue;
			end
			osc(1, 13);
			chk(run, 0);
			osc(1, 1);
			if (tbl[i][3] > 0) begin
				osc(0, tbl[i][3] - 1);
				chk(run, 0);
				osc(0, 1);
			end
			wait_run;
			c = rnd[7:0];
			bus(1, 2'h0, c);
			bus(1, 2'h1, ~c);
			rdx(2'h0, c);
			rdx(2'h3, 8'h00);
			// Status while running: state code 3, not invalid, run, divide flag, source on
			rdx(2'h1, {4'h3, 2'b01, !div, 1'b1});
			// Every sleep mode; only power-down and power-save time the wake
			for (int m = 0; m < 5; m++) begin
				req <= 1;
				mode <= 3'(m);
				cyc(1);
				req <= 0;
				cyc(2);
				chk({core, peri, pmem, asy, conv}, en_tbl[m]);
				chk(run, 0);
				wake <= 1;
				cyc(1);
				wake <= 0;
				if (m == 2 || m == 3) begin
					osc(1, tbl[i][4] - 1);
					chk(run, 0);
					osc(1, 1);
				end
				wait_run;
			end
		end
		end_sim;
	end
endmodule
